// *** src/sba_datapath.sv ***
// Overview of operation
// - sixteen-bit mapping and arithmetic apply only while the mode flag is set.
// - single bus into full accumulator: bits 47..32, clear 23..8, sign-extend extension.
// - both buses into full accumulator: primary to 47..32, secondary to 23..8.
// - single bus into word register: low 16 bits go to top 16 bits.
// - move into extension loads bus bits 7..0 only, rest untouched.
// - both buses into word pair: top 16 bits of each word, extension kept.
// - word register read: top 16 bits on bus 15..0, zeros above, unlimited.
// - extension read: 8 bits on bus 7..0, bit 7 copied into 23..8.
// - accumulator word pair read: top 16 bits of each word, zero-filled, unlimited.
// - full accumulator to one bus: scaled, limited 16 bits, sign extended.
// - full accumulator to both buses: limit to 32 bits, upper signed, lower zero-filled.
// - input pair read: high word top bits primary, low word secondary, zero-filled.
// - reading an input word just written may show undefined bits 23..16.
// - short immediate into upper/lower word unsigned at 15..8, extension at 7..0.
// - short immediate into full accumulator or input word is a signed fraction.
// - lower and upper words form one contiguous number for shifts and arithmetic.
// - limit to 007fff/008000 single and 007fff00ffff double precision.
// - operand low 8 bits read as zero, results written with them zero.
// - rounding acts at lower-word bit 23, moved by the scaling mode.
// - saturation values 007fff00ffff00 positive and ff800000000000 negative.
// - carry enters at lower-word lsb; logic and rotate act on 16 bits.
// - shifted multiply-accumulate shifts the accumulator right by 16 bits.
// - four-step double precision multiply is not supported in this mode.
// - bit operations number bits 0..15 within the 16-bit word.
// - field operations use 16-bit positions; insert offset bias is software's.
`timescale 1ns/1ns
`default_nettype none
module sba_datapath import sba_pkg::*; (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ce,
	// mode control
	input wire logic i_sixteen_bit_mode_flag,
	input wire sba_scale_t i_scale_mode,
	input wire logic i_sat_enable,
	// bus to register moves
	input wire logic i_mv_wr,
	input wire sba_reg_t i_mv_dst,
	input wire logic [23:0] i_primary_data_bus,
	input wire logic [23:0] i_secondary_data_bus,
	// short immediate loads
	input wire logic i_imm_wr,
	input wire sba_reg_t i_imm_dst,
	input wire logic [7:0] i_imm,
	// register to bus moves
	input wire logic i_mv_rd,
	input wire sba_reg_t i_mv_src,
	// arithmetic command
	input wire logic i_alu_valid,
	input wire sba_op_t i_alu_op,
	input wire logic i_alu_dst,
	input wire sba_reg_t i_alu_src,
	input wire sba_reg_t i_alu_src2,
	input wire logic [4:0] i_bit_num,
	input wire logic [4:0] i_field_width,
	// bus results
	output logic [23:0] o_primary_data_bus,
	output logic [23:0] o_secondary_data_bus,
	output logic o_bus_valid,
	output logic o_limited,
	// state
	output logic [55:0] o_acc_one,
	output logic [55:0] o_acc_two,
	output logic o_carry,
	output logic o_saturated
);

	logic [55:0] acc_reg [2];
	logic [55:0] acc_next [2];
	logic [23:0] in_reg [4];
	logic carry_reg;
	logic m;

	// which accumulator a selector names
	function automatic logic f_acc_of(input sba_reg_t r);
		f_acc_of = (r == R_BL) || (r == R_BU) || (r == R_BE) || (r == R_B) ||
			(r == R_BP) || (r == R_BD);
	endfunction

	// which part of an accumulator a selector names
	function automatic sba_part_t f_part(input sba_reg_t r);
		case (r)
			R_A, R_B: f_part = P_FULL;
			R_AD, R_BD: f_part = P_DUAL;
			R_AU, R_BU: f_part = P_UP;
			R_AL, R_BL: f_part = P_LOW;
			R_AE, R_BE: f_part = P_TOP;
			R_AP, R_BP: f_part = P_PAIR;
			default: f_part = P_NONE;
		endcase
	endfunction

	function automatic logic f_is_word(input sba_reg_t r);
		f_is_word = (r == R_XL) || (r == R_XH) || (r == R_YL) || (r == R_YH);
	endfunction

	function automatic logic [1:0] f_word_idx(input sba_reg_t r);
		f_word_idx = 2'(r - R_XL);
	endfunction

	// input word as an arithmetic operand; low byte dropped in sixteen-bit mode
	function automatic logic [55:0] f_word_op(input logic [23:0] w, input logic md);
		f_word_op = md ? {{24{w[23]}}, w[23:8], 16'h0000} : {{8{w[23]}}, w, 24'h000000};
	endfunction

	function automatic logic [23:0] f_mul_op(input logic [23:0] w, input logic md);
		f_mul_op = md ? {{8{w[23]}}, w[23:8]} : w;
	endfunction

	assign m = i_sixteen_bit_mode_flag;

	// arithmetic unit
	logic [55:0] alu_w;
	logic [55:0] alu_s;
	logic [55:0] alu_b;
	logic [55:0] alu_r;
	logic [56:0] t57;
	logic [40:0] t41;
	logic [47:0] prod48;
	logic [55:0] prod56;
	logic [5:0] round_pos;
	logic [5:0] bit_pos;
	logic [23:0] fld;
	logic alu_cin;
	logic alu_sub;
	logic alu_c;
	logic alu_wr;
	logic alu_arith;
	logic alu_sat;
	logic [55:0] alu_acc;

	always_comb begin
		alu_w = f_work(acc_reg[i_alu_dst], m);
		if (f_is_word(i_alu_src)) begin
			alu_s = f_word_op(in_reg[f_word_idx(i_alu_src)], m);
		end else if (f_part(i_alu_src) == P_FULL) begin
			alu_s = f_work(acc_reg[f_acc_of(i_alu_src)], m);
		end else begin
			alu_s = 56'h0;
		end
		alu_sub = (i_alu_op == OP_SUB) || (i_alu_op == OP_SWC);
		alu_cin = (i_alu_op == OP_ADC) || (i_alu_op == OP_SWC) ? carry_reg : 1'b0;
		alu_b = alu_sub ? ~alu_s : alu_s;
		alu_cin = alu_sub ? ~alu_cin : alu_cin;
		// carry enters at bit 0 of the working number, the lower word's lsb
		t57 = {1'b0, alu_w} + {1'b0, alu_b} + {56'h0, alu_cin};
		t41 = {1'b0, alu_w[39:0]} + {1'b0, alu_b[39:0]} + {40'h0, alu_cin};
		prod48 = 48'($signed(f_mul_op(in_reg[f_word_idx(i_alu_src)], m)) *
			$signed(f_mul_op(in_reg[f_word_idx(i_alu_src2)], m)));
		prod56 = m ? {{24{prod48[30]}}, prod48[30:0], 1'b0} :
			{{8{prod48[46]}}, prod48[46:0], 1'b0};
		round_pos = m ? ROUND_POS16 : ROUND_POS24;
		if (i_scale_mode == SC_DOWN) begin
			round_pos = round_pos + 6'h01;
		end else if (i_scale_mode == SC_UP) begin
			round_pos = round_pos - 6'h01;
		end
		// only 0..15 are meaningful in sixteen-bit mode; 16..23 reach the extension
		bit_pos = (m ? BIT_BASE16 : BIT_BASE24) + {1'b0, i_bit_num};
		fld = m ? {8'h00, alu_s[31:16]} : alu_s[47:24];
		alu_r = alu_w;
		alu_c = carry_reg;
		alu_wr = 1'b1;
		alu_arith = 1'b0;
		case (i_alu_op)
			OP_ADD, OP_SUB, OP_ADC, OP_SWC: begin
				alu_r = t57[55:0];
				alu_c = (m ? t41[40] : t57[56]) ^ alu_sub;
				alu_arith = 1'b1;
			end
			OP_AND: begin
				alu_r = alu_w & (alu_s | ~(m ? LOGIC_MASK16 : LOGIC_MASK24));
			end
			OP_OR: begin
				alu_r = alu_w | (alu_s & (m ? LOGIC_MASK16 : LOGIC_MASK24));
			end
			OP_EOR: begin
				alu_r = alu_w ^ (alu_s & (m ? LOGIC_MASK16 : LOGIC_MASK24));
			end
			OP_ROL: begin
				if (m) begin
					alu_r[31:16] = {alu_w[30:16], carry_reg};
					alu_c = alu_w[31];
				end else begin
					alu_r[47:24] = {alu_w[46:24], carry_reg};
					alu_c = alu_w[47];
				end
			end
			OP_ROR: begin
				if (m) begin
					alu_r[31:16] = {carry_reg, alu_w[31:17]};
					alu_c = alu_w[16];
				end else begin
					alu_r[47:24] = {carry_reg, alu_w[47:25]};
					alu_c = alu_w[24];
				end
			end
			OP_ASL: begin
				alu_r = {alu_w[54:0], 1'b0};
				alu_c = m ? alu_w[39] : alu_w[55];
				alu_arith = 1'b1;
			end
			OP_ASR: begin
				alu_r = {alu_w[55], alu_w[55:1]};
				alu_c = alu_w[0];
			end
			OP_ROUND: begin
				alu_r = (alu_w + (56'h1 << round_pos)) & ~((56'h2 << round_pos) - 56'h1);
				alu_arith = 1'b1;
			end
			OP_MPY: begin
				alu_r = prod56;
				alu_arith = 1'b1;
			end
			OP_MAC: begin
				alu_r = alu_w + prod56;
				alu_arith = 1'b1;
			end
			OP_SMAC: begin
				// the working number already holds 16-bit words, so 16 is one word
				alu_r = 56'($signed(alu_w) >>> (m ? SMAC_SHIFT16 : SMAC_SHIFT24)) + prod56;
				alu_arith = 1'b1;
			end
			OP_BSET: begin
				alu_r = alu_w | (56'h1 << bit_pos);
				alu_c = alu_w[bit_pos];
			end
			OP_BCLR: begin
				alu_r = alu_w & ~(56'h1 << bit_pos);
				alu_c = alu_w[bit_pos];
			end
			OP_BTGL: begin
				alu_r = alu_w ^ (56'h1 << bit_pos);
				alu_c = alu_w[bit_pos];
			end
			OP_BTST: begin
				alu_c = alu_w[bit_pos];
				alu_wr = 1'b0;
			end
			OP_EXTU: begin
				// field placed at the 16-bit data positions of the upper word
				fld = (fld >> i_bit_num) & ~(24'hffffff << i_field_width);
				alu_r = m ? {24'h0, fld[15:0], 16'h0} : {8'h0, fld, 24'h0};
			end
			default: begin
				alu_wr = 1'b0;
			end
		endcase
		// detection kept at the double-word boundary of each mode
		alu_sat = i_sat_enable && alu_arith && (m ? !(&alu_r[39:31] || !(|alu_r[39:31])) :
			!(&alu_r[55:47] || !(|alu_r[55:47])));
		if (alu_sat) begin
			if (m) begin
				alu_acc = alu_r[39] ? SAT16_NEG : SAT16_POS;
			end else begin
				alu_acc = alu_r[55] ? SAT24_NEG : SAT24_POS;
			end
		end else begin
			alu_acc = f_unwork(alu_r, m);
		end
	end

	// accumulator next state: arithmetic first, then moves and immediates
	logic [23:0] mv_p;
	logic [23:0] mv_q;
	logic [23:0] imm_w;
	logic [23:0] imm_f;

	always_comb begin
		mv_p = f_in_word(i_primary_data_bus, m);
		mv_q = f_in_word(i_secondary_data_bus, m);
		imm_w = m ? {8'h00, i_imm, 8'h00} : {16'h0000, i_imm};
		imm_f = {i_imm, 16'h0000};
		for (int k = 0; k < 2; k++) begin
			acc_next[k] = acc_reg[k];
			if (i_alu_valid && alu_wr && (i_alu_dst == 1'(k))) begin
				acc_next[k] = alu_acc;
			end
			if (i_mv_wr && (f_acc_of(i_mv_dst) == 1'(k))) begin
				case (f_part(i_mv_dst))
					P_FULL: acc_next[k] = {{8{mv_p[23]}}, mv_p, 24'h000000};
					P_DUAL: acc_next[k] = {{8{mv_p[23]}}, mv_p, mv_q};
					P_UP: acc_next[k][47:24] = mv_p;
					P_LOW: acc_next[k][23:0] = mv_p;
					P_TOP: acc_next[k][55:48] = i_primary_data_bus[7:0];
					P_PAIR: acc_next[k][47:0] = {mv_p, mv_q};
					default: acc_next[k] = acc_next[k];
				endcase
			end
			if (i_imm_wr && (f_acc_of(i_imm_dst) == 1'(k))) begin
				case (f_part(i_imm_dst))
					P_FULL: acc_next[k] = {{8{i_imm[7]}}, imm_f, 24'h000000};
					P_UP: acc_next[k][47:24] = imm_w;
					P_LOW: acc_next[k][23:0] = imm_w;
					P_TOP: acc_next[k][55:48] = i_imm;
					default: acc_next[k] = acc_next[k];
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_reg[0] <= ACC_RST;
			acc_reg[1] <= ACC_RST;
		end else if (i_ce) begin
			acc_reg[0] <= acc_next[0];
			acc_reg[1] <= acc_next[1];
		end
	end

	// input word registers
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int k = 0; k < 4; k++) begin
				in_reg[k] <= WORD_RST;
			end
		end else if (i_ce) begin
			if (i_mv_wr && f_is_word(i_mv_dst)) begin
				in_reg[f_word_idx(i_mv_dst)] <= mv_p;
			end else if (i_mv_wr && (i_mv_dst == R_X || i_mv_dst == R_Y)) begin
				in_reg[i_mv_dst == R_X ? 2'd1 : 2'd3] <= mv_p;
				in_reg[i_mv_dst == R_X ? 2'd0 : 2'd2] <= mv_q;
			end
			if (i_imm_wr && f_is_word(i_imm_dst)) begin
				in_reg[f_word_idx(i_imm_dst)] <= imm_f;
			end
		end
	end

	// flags
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			carry_reg <= 1'b0;
			o_saturated <= 1'b0;
		end else if (i_ce) begin
			if (i_alu_valid) begin
				carry_reg <= alu_c;
			end
			o_saturated <= i_alu_valid && alu_sat;
		end
	end

	// bus reads; the limiter sees the accumulator named by the source
	logic [23:0] sl_single;
	logic [23:0] sl_hi;
	logic [23:0] sl_lo;
	logic sl_lim;
	logic [55:0] rd_acc;
	logic [23:0] rd_w0;
	logic [23:0] rd_w1;

	assign rd_acc = acc_reg[f_acc_of(i_mv_src)];
	assign rd_w0 = in_reg[i_mv_src == R_Y ? 2'd2 : 2'd0];
	assign rd_w1 = in_reg[i_mv_src == R_Y ? 2'd3 : 2'd1];

	sba_scale_limit u_limit (
		.i_acc(rd_acc),
		.i_mode16(m),
		.i_scale(i_scale_mode),
		.o_single(sl_single),
		.o_dbl_hi(sl_hi),
		.o_dbl_lo(sl_lo),
		.o_limited(sl_lim)
	);

	// a word written in the same cycle is read at its old value in every bit, which goes beyond
	// the undefined-bits allowance for bits 23..16
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_primary_data_bus <= WORD_RST;
			o_secondary_data_bus <= WORD_RST;
			o_bus_valid <= 1'b0;
			o_limited <= 1'b0;
		end else if (i_ce) begin
			o_bus_valid <= i_mv_rd;
			o_limited <= 1'b0;
			if (i_mv_rd) begin
				o_secondary_data_bus <= WORD_RST;
				if (f_is_word(i_mv_src)) begin
					o_primary_data_bus <= f_out_word(in_reg[f_word_idx(i_mv_src)], m);
				end else if (i_mv_src == R_X || i_mv_src == R_Y) begin
					o_primary_data_bus <= f_out_word(rd_w1, m);
					o_secondary_data_bus <= f_out_word(rd_w0, m);
				end else begin
					case (f_part(i_mv_src))
						P_FULL: begin
							o_primary_data_bus <= sl_single;
							o_limited <= sl_lim;
						end
						P_DUAL: begin
							o_primary_data_bus <= sl_hi;
							o_secondary_data_bus <= sl_lo;
							o_limited <= sl_lim;
						end
						P_UP: o_primary_data_bus <= f_out_word(rd_acc[47:24], m);
						P_LOW: o_primary_data_bus <= f_out_word(rd_acc[23:0], m);
						P_TOP: o_primary_data_bus <= {{16{rd_acc[55]}}, rd_acc[55:48]};
						P_PAIR: begin
							o_primary_data_bus <= f_out_word(rd_acc[47:24], m);
							o_secondary_data_bus <= f_out_word(rd_acc[23:0], m);
						end
						default: o_primary_data_bus <= WORD_RST;
					endcase
				end
			end
		end
	end

	// state mirrors
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_acc_one <= ACC_RST;
			o_acc_two <= ACC_RST;
			o_carry <= 1'b0;
		end else if (i_ce) begin
			o_acc_one <= acc_next[0];
			o_acc_two <= acc_next[1];
			o_carry <= i_alu_valid ? alu_c : carry_reg;
		end
	end

endmodule // sba_datapath
`default_nettype wire

// *** src/sba_pkg.sv ***
package sba_pkg;

	// limiting and saturation values
	localparam logic [23:0] LIM16_POS = 24'h007fff;
	localparam logic [23:0] LIM16_NEG = 24'h008000;
	localparam logic [47:0] LIM32_POS = 48'h007fff00ffff;
	localparam logic [47:0] LIM32_NEG = 48'h008000000000;
	localparam logic [23:0] LIM24_POS = 24'h7fffff;
	localparam logic [23:0] LIM24_NEG = 24'h800000;
	localparam logic [47:0] LIM48_POS = 48'h7fffffffffff;
	localparam logic [47:0] LIM48_NEG = 48'h800000000000;
	localparam logic [55:0] SAT16_POS = 56'h007fff00ffff00;
	localparam logic [55:0] SAT16_NEG = 56'hff800000000000;
	localparam logic [55:0] SAT24_POS = 56'h007fffffffffff;
	localparam logic [55:0] SAT24_NEG = 56'hff800000000000;

	// field positions in the working number
	localparam logic [55:0] LOGIC_MASK16 = 56'h000000ffff0000;
	localparam logic [55:0] LOGIC_MASK24 = 56'h00ffffff000000;
	localparam logic [5:0] SMAC_SHIFT16 = 6'h10;
	localparam logic [5:0] SMAC_SHIFT24 = 6'h18;
	localparam logic [5:0] ROUND_POS16 = 6'h0f;
	localparam logic [5:0] ROUND_POS24 = 6'h17;
	localparam logic [5:0] BIT_BASE16 = 6'h10;
	localparam logic [5:0] BIT_BASE24 = 6'h18;

	// reset values
	localparam logic [55:0] ACC_RST = 56'h0;
	localparam logic [23:0] WORD_RST = 24'h0;

	typedef enum logic [1:0] {
		SC_NONE = 2'b00,
		SC_DOWN = 2'b01,
		SC_UP = 2'b10
	} sba_scale_t;

	typedef enum logic [4:0] {
		R_NONE = 5'b00000,
		R_XL = 5'b00001,
		R_XH = 5'b00010,
		R_YL = 5'b00011,
		R_YH = 5'b00100,
		R_AL = 5'b00101,
		R_AU = 5'b00110,
		R_AE = 5'b00111,
		R_A = 5'b01000,
		R_BL = 5'b01001,
		R_BU = 5'b01010,
		R_BE = 5'b01011,
		R_B = 5'b01100,
		R_X = 5'b01101,
		R_Y = 5'b01110,
		R_AP = 5'b01111,
		R_BP = 5'b10000,
		R_AD = 5'b10001,
		R_BD = 5'b10010
	} sba_reg_t;

	typedef enum logic [2:0] {
		P_NONE = 3'b000,
		P_FULL = 3'b001,
		P_DUAL = 3'b010,
		P_UP = 3'b011,
		P_LOW = 3'b100,
		P_TOP = 3'b101,
		P_PAIR = 3'b110
	} sba_part_t;

	typedef enum logic [4:0] {
		OP_NOP = 5'b00000,
		OP_ADD = 5'b00001,
		OP_SUB = 5'b00010,
		OP_ADC = 5'b00011,
		OP_SWC = 5'b00100,
		OP_AND = 5'b00101,
		OP_OR = 5'b00110,
		OP_EOR = 5'b00111,
		OP_ROL = 5'b01000,
		OP_ROR = 5'b01001,
		OP_ASL = 5'b01010,
		OP_ASR = 5'b01011,
		OP_ROUND = 5'b01100,
		OP_MPY = 5'b01101,
		OP_MAC = 5'b01110,
		OP_SMAC = 5'b01111,
		OP_BSET = 5'b10000,
		OP_BCLR = 5'b10001,
		OP_BTGL = 5'b10010,
		OP_BTST = 5'b10011,
		OP_EXTU = 5'b10100
	} sba_op_t;

	// accumulator to contiguous working number
	function automatic logic [55:0] f_work(input logic [55:0] a, input logic m);
		f_work = m ? {{16{a[55]}}, a[55:32], a[23:8]} : a;
	endfunction

	// working number back to accumulator, low bytes forced to zero in sixteen-bit mode only
	function automatic logic [55:0] f_unwork(input logic [55:0] w, input logic m);
		f_unwork = m ? {w[39:32], w[31:16], 8'h00, w[15:0], 8'h00} : w;
	endfunction

	function automatic logic [23:0] f_in_word(input logic [23:0] b, input logic m);
		f_in_word = m ? {b[15:0], 8'h00} : b;
	endfunction

	function automatic logic [23:0] f_out_word(input logic [23:0] w, input logic m);
		f_out_word = m ? {8'h00, w[23:8]} : w;
	endfunction

endpackage

// *** src/sba_scale_limit.sv ***
`timescale 1ns/1ns
`default_nettype none
module sba_scale_limit import sba_pkg::*; (
	// accumulator and mode
	input wire logic [55:0] i_acc,
	input wire logic i_mode16,
	input wire sba_scale_t i_scale,
	// scaled and limited words
	output logic [23:0] o_single,
	output logic [23:0] o_dbl_hi,
	output logic [23:0] o_dbl_lo,
	output logic o_limited
);

	logic [55:0] w;
	logic [55:0] s;
	logic fit;

	always_comb begin
		w = f_work(i_acc, i_mode16);
		case (i_scale)
			SC_DOWN: s = {w[55], w[55:1]};
			SC_UP: s = {w[54:0], 1'b0};
			default: s = w;
		endcase
		// lower and upper words taken as one number, so the shift is exact
		if (i_mode16) begin
			fit = &s[55:31] | ~|s[55:31];
			o_single = fit ? {{8{s[31]}}, s[31:16]} : (s[55] ? LIM16_NEG : LIM16_POS);
			o_dbl_hi = fit ? {{8{s[31]}}, s[31:16]} : (s[55] ? LIM32_NEG[47:24] : LIM32_POS[47:24]);
			o_dbl_lo = fit ? {8'h00, s[15:0]} : (s[55] ? LIM32_NEG[23:0] : LIM32_POS[23:0]);
		end else begin
			fit = &s[55:47] | ~|s[55:47];
			o_single = fit ? s[47:24] : (s[55] ? LIM24_NEG : LIM24_POS);
			o_dbl_hi = fit ? s[47:24] : (s[55] ? LIM48_NEG[47:24] : LIM48_POS[47:24]);
			o_dbl_lo = fit ? s[23:0] : (s[55] ? LIM48_NEG[23:0] : LIM48_POS[23:0]);
		end
		o_limited = ~fit;
	end

endmodule // sba_scale_limit
`default_nettype wire

// *** bench/sba_datapath_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module sba_datapath_monitor import sba_pkg::*; (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// requests
	input wire logic i_ce,
	input wire logic i_sixteen_bit_mode_flag,
	input wire logic i_mv_wr,
	input wire sba_reg_t i_mv_dst,
	input wire logic [23:0] i_primary_data_bus,
	input wire logic [23:0] i_secondary_data_bus,
	input wire logic i_imm_wr,
	input wire logic i_alu_valid,
	input wire logic i_mv_rd,
	input wire sba_reg_t i_mv_src,
	// results
	input wire logic [23:0] o_primary_data_bus,
	input wire logic [23:0] o_secondary_data_bus,
	input wire logic o_limited,
	input wire logic [55:0] o_acc_one,
	input wire logic [55:0] o_acc_two
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	// one-cycle copies keep the properties short
	logic [23:0] pb_q;
	logic [23:0] sb_q;
	logic [55:0] c1_q;
	always_ff @(posedge i_mclk) begin
		pb_q <= i_primary_data_bus;
		sb_q <= i_secondary_data_bus;
		c1_q <= o_acc_one;
	end
	// a lone move, so no same-cycle immediate overrides it and no alu result alters the bits it keeps
	sequence s_mv(sba_reg_t d, logic m);
		i_ce && i_mv_wr && i_mv_dst == d && !i_imm_wr && !i_alu_valid
			&& i_sixteen_bit_mode_flag == m;
	endsequence
	sequence s_rd(sba_reg_t d);
		i_ce && i_mv_rd && i_mv_src == d && i_sixteen_bit_mode_flag;
	endsequence
	AST_MV_FULL:
	assert property (s_mv(R_A, 1'b1) |=> o_acc_one == {{8{pb_q[15]}}, pb_q[15:0], 32'h00000000})
		else $error("full move mapping wrong");
	AST_MV_DUAL:
	assert property (s_mv(R_BD, 1'b1) |=>
		o_acc_two == {{8{pb_q[15]}}, pb_q[15:0], 8'h00, sb_q[15:0], 8'h00})
		else $error("dual move mapping wrong");
	AST_MV_TOP:
	assert property (s_mv(R_AE, 1'b1) |=> o_acc_one == {pb_q[7:0], c1_q[47:0]})
		else $error("extension move wrong");
	AST_RD_WORD:
	assert property (s_rd(R_AU) |=> o_primary_data_bus == {8'h00, c1_q[47:32]})
		else $error("word read wrong");
	AST_RD_TOP:
	assert property (s_rd(R_AE) |=> o_primary_data_bus == {{16{c1_q[55]}}, c1_q[55:48]})
		else $error("extension read wrong");
	AST_RD_PAIR:
	assert property (s_rd(R_AP) |=> o_primary_data_bus == {8'h00, c1_q[47:32]}
		&& o_secondary_data_bus == {8'h00, c1_q[23:8]})
		else $error("pair read wrong");
	AST_RD_LIMIT:
	assert property (s_rd(R_A) ##1 o_limited |-> o_primary_data_bus inside {LIM16_POS, LIM16_NEG})
		else $error("limited value wrong");
	AST_MODE_OFF:
	assert property (s_mv(R_A, 1'b0) |=> o_acc_one == {{8{pb_q[23]}}, pb_q, 24'h000000})
		else $error("normal width move wrong");
endmodule // sba_datapath_monitor
`default_nettype wire

// *** bench/sba_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sba_core_model import sba_pkg::*; (
	// core clock
	input wire logic i_mclk,
	// mode and moves
	output logic o_mode,
	output logic o_mv_wr,
	output sba_reg_t o_mv_dst,
	output logic [23:0] o_pbus,
	output logic [23:0] o_sbus,
	output logic o_imm_wr,
	output sba_reg_t o_imm_dst,
	output logic [7:0] o_imm,
	output logic o_mv_rd,
	output sba_reg_t o_mv_src,
	// arithmetic
	output logic o_alu_valid,
	output sba_op_t o_alu_op,
	output logic o_alu_dst,
	output sba_reg_t o_alu_src,
	output sba_reg_t o_alu_src2
);
	initial begin
		o_mode = 1'b1;
		{o_mv_wr, o_imm_wr, o_mv_rd, o_alu_valid} = 4'h0;
		o_mv_dst = R_NONE;
		o_imm_dst = R_NONE;
		o_mv_src = R_NONE;
		o_alu_src = R_NONE;
		o_alu_src2 = R_XL;
		o_alu_op = OP_NOP;
		o_alu_dst = 1'b0;
		o_pbus = 24'h000000;
		o_sbus = 24'h000000;
		o_imm = 8'h00;
	end
	// k picks move, immediate, read, alu; starting on a fresh edge avoids double drives
	task automatic op(input logic [3:0] k, input sba_reg_t r, input logic [23:0] p,
		input logic [23:0] s);
		@(posedge i_mclk);
		#1;
		o_mv_dst = r;
		o_imm_dst = r;
		o_mv_src = r;
		o_alu_src = r;
		o_pbus = p;
		o_sbus = s;
		o_imm = p[7:0];
		o_alu_op = sba_op_t'(p[4:0]);
		{o_mv_wr, o_imm_wr, o_mv_rd, o_alu_valid} = k;
		@(posedge i_mclk);
		#1;
		{o_mv_wr, o_imm_wr, o_mv_rd, o_alu_valid} = 4'h0;
		// a released bus must not keep showing the old word
		o_pbus = ~p;
		o_sbus = ~s;
	endtask
	// switching mode needs two quiet cycles
	task automatic set_mode(input logic m);
		@(posedge i_mclk);
		#1;
		o_mode = m;
		repeat (2) @(posedge i_mclk);
	endtask
endmodule // sba_core_model
`default_nettype wire

// *** bench/sba_datapath_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
bind sba_datapath sba_datapath_monitor u_mon (.i_mclk, .i_resetn, .i_ce,
	.i_sixteen_bit_mode_flag, .i_mv_wr, .i_mv_dst, .i_primary_data_bus,
	.i_secondary_data_bus, .i_imm_wr, .i_alu_valid, .i_mv_rd, .i_mv_src,
	.o_primary_data_bus, .o_secondary_data_bus, .o_limited, .o_acc_one, .o_acc_two);
module sba_datapath_tb_top import sba_pkg::*;;
	localparam logic [3:0] K_MV = 4'h8;
	localparam logic [3:0] K_IMM = 4'h4;
	localparam logic [3:0] K_RD = 4'h2;
	localparam logic [3:0] K_ALU = 4'h1;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_ce = 1'b1;
	sba_scale_t i_scale_mode = SC_NONE;
	logic i_sat_enable = 1'b0;
	logic [4:0] i_bit_num = 5'h00;
	logic [4:0] i_field_width = 5'h00;
	logic i_sixteen_bit_mode_flag, i_mv_wr, i_imm_wr, i_mv_rd, i_alu_valid, i_alu_dst;
	sba_reg_t i_mv_dst, i_imm_dst, i_mv_src, i_alu_src, i_alu_src2;
	sba_op_t i_alu_op;
	logic [23:0] i_primary_data_bus, i_secondary_data_bus;
	logic [23:0] o_primary_data_bus, o_secondary_data_bus;
	logic [7:0] i_imm;
	logic o_bus_valid, o_limited, o_carry, o_saturated;
	logic [55:0] o_acc_one, o_acc_two;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	always #10 i_mclk = ~i_mclk;
	sba_datapath DUT (.i_mclk, .i_resetn, .i_ce, .i_sixteen_bit_mode_flag, .i_scale_mode,
		.i_sat_enable, .i_mv_wr, .i_mv_dst, .i_primary_data_bus, .i_secondary_data_bus,
		.i_imm_wr, .i_imm_dst, .i_imm, .i_mv_rd, .i_mv_src, .i_alu_valid, .i_alu_op,
		.i_alu_dst, .i_alu_src, .i_alu_src2, .i_bit_num, .i_field_width,
		.o_primary_data_bus, .o_secondary_data_bus, .o_bus_valid, .o_limited,
		.o_acc_one, .o_acc_two, .o_carry, .o_saturated);
	sba_core_model u_core (.i_mclk, .o_mode(i_sixteen_bit_mode_flag), .o_mv_wr(i_mv_wr),
		.o_mv_dst(i_mv_dst), .o_pbus(i_primary_data_bus), .o_sbus(i_secondary_data_bus),
		.o_imm_wr(i_imm_wr), .o_imm_dst(i_imm_dst), .o_imm(i_imm), .o_mv_rd(i_mv_rd),
		.o_mv_src(i_mv_src), .o_alu_valid(i_alu_valid), .o_alu_op(i_alu_op),
		.o_alu_dst(i_alu_dst), .o_alu_src(i_alu_src), .o_alu_src2(i_alu_src2));
	task automatic check(input logic [55:0] seen, input logic [55:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// whole run needs under a hundred cycles
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic t_full_moves;
		u_core.op(K_MV, R_A, 24'h5a8123, 24'h000000);
		check(o_acc_one, 56'hff812300000000);
		u_core.op(K_MV, R_BD, 24'h001234, 24'h00abcd);
		check(o_acc_two, 56'h00123400abcd00);
	endtask
	task automatic t_part_moves;
		u_core.op(K_MV, R_AL, 24'hff5566, 24'h000000);
		check(o_acc_one, 56'hff812300556600);
		u_core.op(K_MV, R_AE, 24'h1234f7, 24'h000000);
		check(o_acc_one, 56'hf7812300556600);
		u_core.op(K_MV, R_BP, 24'h000011, 24'h000022);
		check(o_acc_two, 56'h00001100002200);
	endtask
	task automatic t_part_reads;
		u_core.op(K_RD, R_AU, 24'h000000, 24'h000000);
		check({o_bus_valid, o_primary_data_bus}, 25'h1008123);
		u_core.op(K_RD, R_AE, 24'h000000, 24'h000000);
		check(o_primary_data_bus, 24'hfffff7);
		u_core.op(K_RD, R_AP, 24'h000000, 24'h000000);
		check({o_primary_data_bus, o_secondary_data_bus}, 48'h008123005566);
	endtask
	task automatic t_full_reads;
		u_core.op(K_RD, R_A, 24'h000000, 24'h000000);
		check({o_limited, o_primary_data_bus}, 25'h1008000);
		u_core.op(K_RD, R_B, 24'h000000, 24'h000000);
		check(o_primary_data_bus, 24'h000011);
		u_core.op(K_RD, R_BD, 24'h000000, 24'h000000);
		check({o_primary_data_bus, o_secondary_data_bus}, 48'h000011000022);
	endtask
	task automatic t_inputs;
		u_core.op(K_MV, R_X, 24'h000033, 24'h000044);
		u_core.op(K_RD, R_X, 24'h000000, 24'h000000);
		check({o_primary_data_bus, o_secondary_data_bus}, 48'h000033000044);
		u_core.op(K_RD, R_XL, 24'h000000, 24'h000000);
		check(o_primary_data_bus, 24'h000044);
	endtask
	task automatic t_imm;
		u_core.op(K_IMM, R_AU, 24'h00009c, 24'h000000);
		check(o_acc_one, 56'hf7009c00556600);
		u_core.op(K_IMM, R_A, 24'h00009c, 24'h000000);
		check(o_acc_one, 56'hff9c0000000000);
	endtask
	task automatic t_alu;
		u_core.op(K_MV, R_A, 24'h000001, 24'h000000);
		u_core.op(K_ALU, R_A, 24'(OP_ASR), 24'h000000);
		check(o_acc_one, 56'h00000000800000);
		u_core.op(K_MV, R_XL, 24'h000002, 24'h000000);
		u_core.op(K_ALU, R_XL, 24'(OP_ADD), 24'h000000);
		check(o_acc_one, 56'h00000200800000);
		i_bit_num = 5'h03;
		u_core.op(K_ALU, R_A, 24'(OP_BSET), 24'h0);
		check(o_acc_one, 56'h00000a00800000);
		u_core.op(K_ALU, R_A, 24'(OP_BTST), 24'h0);
		check(o_carry, 1'b1);
		u_core.op(K_ALU, R_XL, 24'(OP_ADC), 24'h0);
		check(o_acc_one, 56'h00000c00800100);
		u_core.op(K_ALU, R_A, 24'(OP_ROUND), 24'h0);
		check(o_acc_one, 56'h00000d00000000);
		u_core.op(K_ALU, R_XL, 24'(OP_SMAC), 24'h0);
		check(o_acc_one, 56'h00000000001500);
		i_sat_enable = 1'b1;
		u_core.op(K_MV, R_A, 24'h007fff, 24'h0);
		u_core.op(K_ALU, R_A, 24'(OP_ADD), 24'h0);
		check(o_acc_one, 56'h007fff00ffff00);
		check(o_saturated, 1'b1);
		i_sat_enable = 1'b0;
		i_scale_mode = SC_UP;
		u_core.op(K_RD, R_A, 24'h0, 24'h0);
		check({o_limited, o_primary_data_bus}, 25'h1007fff);
		i_scale_mode = SC_NONE;
	endtask
	task automatic t_mode_off;
		u_core.set_mode(1'b0);
		u_core.op(K_MV, R_A, 24'h5a8123, 24'h000000);
		check(o_acc_one, 56'h005a8123000000);
		u_core.set_mode(1'b1);
	endtask
	initial begin
		repeat (2) @(posedge i_mclk);
		#1;
		i_resetn = 1'b1;
		check(o_acc_one, 56'h00000000000000);
		t_full_moves();
		t_part_moves();
		t_part_reads();
		t_full_reads();
		t_inputs();
		t_imm();
		t_alu();
		t_mode_off();
		finish_test();
	end
endmodule // sba_datapath_tb_top
`default_nettype wire
